//--- src/enc_pkg.sv
package enc_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int BAUD_LO = 4800;
  localparam int BAUD_HI = 28800;
  localparam int DIV_LO = CLK_HZ / BAUD_LO;
  localparam int DIV_HI = CLK_HZ / BAUD_HI;
  localparam int DIV_W = 16;
  localparam int TMR_W = 20;

  // ----------------------------------------------------------------
  // times in milliseconds
  // ----------------------------------------------------------------
  localparam int KEY_IND_MS = 1000;
  localparam int CREATE_MS = 15000;
  localparam int FLASH_MS = 500;
  localparam int ENTRY_GAP_MS = 2000;
  localparam int IDLE_LONG_MS = 15 * 60 * 1000;
  localparam int IDLE_SHORT_MS = 30 * 1000;
  localparam int DEBOUNCE_MS = 10;
  localparam int KEY_GAP_MS = 1000;

  // ----------------------------------------------------------------
  // widths and frame layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int KEY_W = 80;
  localparam int CTR_W = 40;
  localparam int MAC_W = 80;
  localparam int PKT_W = DATA_W + CTR_W + MAC_W;
  localparam int ID_W = 16;
  localparam int FRAME_W = KEY_W + CTR_W + ID_W;
  localparam int FRAME_BYTES = FRAME_W / 8;
  localparam int PIN_LEN = 4;
  localparam int CODE_W = 3;
  localparam int NSYNC = DATA_W + 5;

  // input vector positions after the data lines
  localparam int IX_SEND = 8;
  localparam int IX_CREATE = 9;
  localparam int IX_KEY = 10;
  localparam int IX_BAUD = 11;
  localparam int IX_TIMER = 12;
  localparam int NDEB = 10;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_SEND = 3'h1,
    ST_DRAIN = 3'h3,
    ST_KEY_RX = 3'h2,
    ST_KEY_CONF = 3'h6,
    ST_KEY_FINAL = 3'h7,
    ST_KEY_IND = 3'h5,
    ST_PIN_MAKE = 3'h4
  } mode_t;
endpackage

//--- src/pkt_buffer.sv
`timescale 1ns/100ps
module pkt_buffer
#(
  parameter int W = 128
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

//--- src/remote_encoder.sv
`timescale 1ns/100ps
module remote_encoder
#(
  parameter int MS_CYCLES = enc_pkg::MS_CYCLES,
  parameter int DIV_LO = enc_pkg::DIV_LO,
  parameter int DIV_HI = enc_pkg::DIV_HI,
  parameter logic [7:0] CONF_BYTE = 8'ha5
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic KEY_IN,
  input wire logic SEND,
  input wire logic CREATE_PIN,
  input wire logic [enc_pkg::DATA_W-1:0] DATA_IN,
  input wire logic SEL_BAUD,
  input wire logic SEL_TIMER,
  output logic DATA_OUT,
  output logic TRANSMITTER_POWER_ENABLE,
  output logic STATUS_INDICATOR,
  output logic ASLEEP,
  output logic KEY_VALID,
  output logic PIN_SET
);
  import enc_pkg::*;

  mode_t state_q, prev_q;
  logic [NSYNC-1:0] s1_q, s2_q;
  logic [NDEB-1:0] deb_q, debp_q;
  logic [15:0] ms_cnt_q;
  logic ms_tick;
  logic [1:0] init_q;
  logic baud_hi_q;
  logic [DIV_W-1:0] bit_div;
  logic [TMR_W-1:0] tmr_q;
  logic send_rise, create_rise, entry;
  logic [CODE_W-1:0] code;

  // ----------------------------------------------------------------
  // input synchronisers and debouncers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      // key line idles high; a low reset value would fake a start bit
      s1_q <= NSYNC'(1 << IX_KEY);
      s2_q <= NSYNC'(1 << IX_KEY);
    end
    else
    begin
      s1_q <= {SEL_TIMER, SEL_BAUD, KEY_IN, CREATE_PIN, SEND, DATA_IN};
      s2_q <= s1_q;
    end
  end

  assign ms_tick = (ms_cnt_q == 16'(MS_CYCLES - 1));

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ms_cnt_q <= 16'h0;
    else if (ms_tick)
      ms_cnt_q <= 16'h0;
    else
      ms_cnt_q <= ms_cnt_q + 16'h1;
  end

  // a level must hold for the whole debounce time to be taken
  for (genvar i = 0; i < NDEB; i++)
  begin : g_deb
    logic [3:0] dc_q;
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        dc_q <= 4'h0;
        deb_q[i] <= 1'b0;
      end
      else if (s2_q[i] == deb_q[i])
        dc_q <= 4'h0;
      else if (ms_tick)
      begin
        if (dc_q == 4'(DEBOUNCE_MS - 1))
        begin
          deb_q[i] <= s2_q[i];
          dc_q <= 4'h0;
        end
        else
          dc_q <= dc_q + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      debp_q <= '0;
    else
      debp_q <= deb_q;
  end

  assign send_rise = deb_q[IX_SEND] && !debp_q[IX_SEND];
  assign create_rise = deb_q[IX_CREATE] && !debp_q[IX_CREATE];

  // an entry counts on release; lowest line wins if several drop
  always_comb
  begin
    entry = 1'b0;
    code = '0;
    for (int i = DATA_W - 1; i >= 0; i--)
    begin
      if (debp_q[i] && !deb_q[i])
      begin
        entry = 1'b1;
        code = CODE_W'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // bit rate latched once after reset
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      init_q <= 2'h0;
      baud_hi_q <= 1'b0;
    end
    else if (init_q != 2'h3)
    begin
      init_q <= init_q + 2'h1;
      if (init_q == 2'h2)
        baud_hi_q <= s2_q[IX_BAUD];
    end
  end

  assign bit_div = baud_hi_q ? DIV_W'(DIV_HI) : DIV_W'(DIV_LO);

  // ----------------------------------------------------------------
  // key link receiver, 8N1 at the latched rate
  // ----------------------------------------------------------------
  logic rx_busy_q, rx_done_q, keyp_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_busy_q <= 1'b0;
      rx_done_q <= 1'b0;
      keyp_q <= 1'b1;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h0;
    end
    else
    begin
      keyp_q <= s2_q[IX_KEY];
      rx_done_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (keyp_q && !s2_q[IX_KEY])
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= bit_div >> 1;
          rx_bit_q <= 4'h0;
        end
      end
      else if (rx_cnt_q != '0)
        rx_cnt_q <= rx_cnt_q - 1'b1;
      else
      begin
        rx_cnt_q <= bit_div - 1'b1;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && s2_q[IX_KEY])
          rx_busy_q <= 1'b0;
        else if (rx_bit_q == 4'h9)
        begin
          rx_busy_q <= 1'b0;
          rx_done_q <= s2_q[IX_KEY];
        end
        else if (rx_bit_q != 4'h0)
          rx_sh_q <= {s2_q[IX_KEY], rx_sh_q[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // key frame, key store and packet counter
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] frame_q;
  logic [4:0] fcnt_q;
  logic [KEY_W-1:0] key_q;
  logic [CTR_W-1:0] ctr_q;
  logic [ID_W-1:0] id_q;
  logic key_valid_q, key_commit, push_q, push_ok;
  logic [PKT_W-1:0] push_data_q;
  logic buf_ready;

  assign key_commit = (state_q == ST_KEY_FINAL) && rx_done_q
    && (rx_sh_q == CONF_BYTE);
  assign push_ok = push_q && buf_ready;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      frame_q <= '0;
      fcnt_q <= 5'h0;
    end
    else if (rx_done_q && (state_q == ST_SLEEP || state_q == ST_KEY_RX))
    begin
      frame_q <= {rx_sh_q, frame_q[FRAME_W-1:8]};
      fcnt_q <= (state_q == ST_SLEEP) ? 5'h1 : fcnt_q + 5'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      key_q <= '0;
      ctr_q <= '0;
      id_q <= '0;
      key_valid_q <= 1'b0;
    end
    else if (key_commit)
    begin
      {id_q, ctr_q, key_q} <= frame_q;
      key_valid_q <= 1'b1;
    end
    else if (push_ok && state_q == ST_SEND)
    begin
      ctr_q <= ctr_q - 1'b1;
      if (ctr_q <= CTR_W'(1))
      begin
        key_valid_q <= 1'b0;
        key_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  logic tx_idle, unlocked_q, pin_set_q, pin_done;
  logic [1:0] pidx_q;

  assign pin_done = (state_q == ST_PIN_MAKE) && entry && pidx_q == 2'h3;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      state_q <= ST_SLEEP;
    else
    begin
      case (state_q)
        ST_SLEEP:
          if (rx_done_q)
            state_q <= ST_KEY_RX;
          else if (send_rise && key_valid_q
            && (!pin_set_q || unlocked_q))
            state_q <= ST_SEND;
          else if (create_rise)
            state_q <= ST_PIN_MAKE;
        ST_KEY_RX:
          if (fcnt_q == 5'(FRAME_BYTES))
            state_q <= ST_KEY_CONF;
          else if (tmr_q >= TMR_W'(KEY_GAP_MS))
            state_q <= ST_SLEEP;
        ST_KEY_CONF:
          if (!push_q && tx_idle)
            state_q <= ST_KEY_FINAL;
        ST_KEY_FINAL:
          if (key_commit)
            state_q <= ST_KEY_IND;
          else if (tmr_q >= TMR_W'(KEY_GAP_MS))
            state_q <= ST_SLEEP;
        ST_KEY_IND:
          if (tmr_q >= TMR_W'(KEY_IND_MS))
            state_q <= ST_SLEEP;
        ST_SEND:
          if (!deb_q[IX_SEND] || !key_valid_q)
            state_q <= ST_DRAIN;
        ST_DRAIN:
          if (!push_q && tx_idle)
            state_q <= ST_SLEEP;
        ST_PIN_MAKE:
          if (create_rise || tmr_q >= TMR_W'(CREATE_MS) || pin_done)
            state_q <= ST_SLEEP;
        default:
          state_q <= ST_SLEEP;
      endcase
    end
  end

  // state timer in milliseconds, cleared on every mode change
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      prev_q <= ST_SLEEP;
      tmr_q <= '0;
    end
    else
    begin
      prev_q <= state_q;
      if (state_q != prev_q)
        tmr_q <= '0;
      else if (ms_tick)
        tmr_q <= tmr_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // packet producer; the cipher core is a keyed stand-in here
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      push_q <= 1'b0;
      push_data_q <= '0;
    end
    else if (push_ok)
      push_q <= 1'b0;
    else if (!push_q && state_q == ST_KEY_RX
      && fcnt_q == 5'(FRAME_BYTES))
    begin
      push_q <= 1'b1;
      push_data_q <= {CONF_BYTE, frame_q[FRAME_W-1 -: ID_W],
        {(PKT_W - 8 - ID_W){1'b0}}};
    end
    else if (!push_q && state_q == ST_SEND && deb_q[IX_SEND]
      && key_valid_q)
    begin
      push_q <= 1'b1;
      push_data_q <= {s2_q[DATA_W-1:0], ctr_q, {ctr_q, ctr_q} ^ key_q}
        ^ {key_q, key_q[PKT_W-KEY_W-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // packet buffer and serialiser
  // ----------------------------------------------------------------
  logic buf_valid, buf_take;
  logic [PKT_W-1:0] buf_data, sh_q;
  logic [7:0] bits_q;
  logic [DIV_W-1:0] tx_div_q;
  logic baud_tick;

  pkt_buffer #(.W(PKT_W)) u_buf (
    .clk(CLK),
    .rst(RST),
    .in_valid(push_q),
    .in_ready(buf_ready),
    .in_data(push_data_q),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );

  assign buf_take = (bits_q == 8'h0);
  assign tx_idle = (bits_q == 8'h0) && !buf_valid;
  assign baud_tick = (tx_div_q == '0);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      tx_div_q <= '0;
    else if (baud_tick)
      tx_div_q <= bit_div - 1'b1;
    else
      tx_div_q <= tx_div_q - 1'b1;
  end

  // one extra bit period returns the line low after the last bit
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sh_q <= '0;
      bits_q <= 8'h0;
      DATA_OUT <= 1'b0;
    end
    else if (bits_q == 8'h0)
    begin
      if (buf_valid)
      begin
        sh_q <= buf_data;
        bits_q <= 8'(PKT_W + 1);
      end
    end
    else if (baud_tick)
    begin
      DATA_OUT <= sh_q[0];
      sh_q <= {1'b0, sh_q[PKT_W-1:1]};
      bits_q <= bits_q - 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // PIN creation and unlock
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] pin_q [PIN_LEN];
  logic [CODE_W-1:0] pnew_q [PIN_LEN];
  logic [1:0] uidx_q;
  logic umatch_q, locked_sleep;
  logic [TMR_W-1:0] gap_q, idle_q;

  assign locked_sleep = (state_q == ST_SLEEP) && pin_set_q && !unlocked_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pidx_q <= 2'h0;
      pin_set_q <= 1'b0;
      for (int i = 0; i < PIN_LEN; i++)
      begin
        pin_q[i] <= '0;
        pnew_q[i] <= '0;
      end
    end
    else if (key_commit)
      pin_set_q <= 1'b0;
    else if (state_q != ST_PIN_MAKE)
      pidx_q <= 2'h0;
    else if (entry)
    begin
      pnew_q[pidx_q] <= code;
      pidx_q <= pidx_q + 2'h1;
      if (pidx_q == 2'h3)
      begin
        pin_q <= '{pnew_q[0], pnew_q[1], pnew_q[2], code};
        pin_set_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      uidx_q <= 2'h0;
      umatch_q <= 1'b1;
      unlocked_q <= 1'b0;
      gap_q <= '0;
      idle_q <= '0;
    end
    else if (key_commit || !pin_set_q)
    begin
      uidx_q <= 2'h0;
      umatch_q <= 1'b1;
      unlocked_q <= 1'b0;
    end
    else if (locked_sleep && entry)
    begin
      gap_q <= '0;
      uidx_q <= uidx_q + 2'h1;
      umatch_q <= umatch_q && (code == pin_q[uidx_q]);
      if (uidx_q == 2'h3)
      begin
        unlocked_q <= umatch_q && (code == pin_q[uidx_q]);
        umatch_q <= 1'b1;
        idle_q <= '0;
      end
    end
    else if (unlocked_q)
    begin
      if (deb_q[IX_SEND] || state_q != ST_SLEEP)
        idle_q <= '0;
      else if (ms_tick)
        idle_q <= idle_q + 1'b1;
      if (idle_q >= (s2_q[IX_TIMER] ? TMR_W'(IDLE_SHORT_MS)
        : TMR_W'(IDLE_LONG_MS)))
        unlocked_q <= 1'b0;
    end
    else if (uidx_q != 2'h0 && ms_tick)
    begin
      gap_q <= gap_q + 1'b1;
      if (gap_q >= TMR_W'(ENTRY_GAP_MS))
      begin
        uidx_q <= 2'h0;
        umatch_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic flash_q;
  logic [TMR_W-1:0] fl_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      flash_q <= 1'b0;
      fl_q <= '0;
    end
    else if (state_q != ST_PIN_MAKE)
    begin
      flash_q <= 1'b1;
      fl_q <= '0;
    end
    else if (ms_tick)
    begin
      fl_q <= fl_q + 1'b1;
      if (fl_q == TMR_W'(FLASH_MS - 1))
      begin
        flash_q <= ~flash_q;
        fl_q <= '0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      TRANSMITTER_POWER_ENABLE <= 1'b0;
      STATUS_INDICATOR <= 1'b0;
    end
    else
    begin
      TRANSMITTER_POWER_ENABLE <= state_q == ST_SEND
        || state_q == ST_DRAIN || state_q == ST_KEY_CONF;
      STATUS_INDICATOR <= (state_q == ST_KEY_IND)
        || (state_q == ST_PIN_MAKE && flash_q && !pin_done)
        || (locked_sleep && |deb_q[DATA_W-1:0]);
    end
  end

  assign ASLEEP = (state_q == ST_SLEEP);
  assign KEY_VALID = key_valid_q;
  assign PIN_SET = pin_set_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_key_done;
    key_commit ##1 state_q == ST_KEY_IND;
  endsequence
  sequence s_ind_on;
    STATUS_INDICATOR [*8];
  endsequence

  a_sleep_tx_off: assert property (
    state_q == ST_SLEEP && prev_q == ST_SLEEP
      |-> !TRANSMITTER_POWER_ENABLE)
    else $error("transmitter on while asleep");
  a_key_indicate: assert property (
    s_key_done |=> s_ind_on)
    else $error("indicator not lit after key transfer");
  a_send_enter: assert property (
    state_q == ST_SLEEP && send_rise && key_valid_q && !pin_set_q
      && !rx_done_q |=> state_q == ST_SEND ##1 TRANSMITTER_POWER_ENABLE)
    else $error("send rise did not start transmission");
  a_drain_end: assert property (
    state_q == ST_DRAIN && !push_q && tx_idle
      |=> state_q == ST_SLEEP ##1 !TRANSMITTER_POWER_ENABLE)
    else $error("transmitter left on after drain");
  a_pin_store: assert property (
    pin_done |=> pin_set_q && state_q == ST_SLEEP ##1 !STATUS_INDICATOR)
    else $error("fourth entry did not store pin");
  a_pin_discard: assert property (
    state_q == ST_PIN_MAKE && create_rise && !pin_done
      |=> state_q == ST_SLEEP && pin_set_q == $past(pin_set_q))
    else $error("cancelled creation changed pin");
  a_pin_erase: assert property (
    key_commit |=> !pin_set_q && !unlocked_q)
    else $error("new key kept pin");
  a_lock_block: assert property (
    locked_sleep |=> state_q != ST_SEND)
    else $error("transmitted while locked");
  a_ctr_zero: assert property (
    push_ok && state_q == ST_SEND && ctr_q == CTR_W'(1)
      |=> !key_valid_q ##1 state_q == ST_DRAIN)
    else $error("key kept after counter ran out");
endmodule

//--- verif/key_link_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// decoder side of the key link
// ------------------------------------------------------------
module key_link_model
#(
  parameter int DIV = 8
)
(
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;

  // 8n1 byte, lsb first; line rests high between bytes
  task send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line <= f[i];
      repeat (DIV) @(posedge clk);
    end
  endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import enc_pkg::*;
  // ------------------------------------------------------------
  // short ms base keeps the one second indicator affordable
  // ------------------------------------------------------------
  localparam int MSC = 20;
  localparam int DEB = 10 * MSC + 20;
  logic clk, rst, send, create, key_line, ind_held, sel_timer;
  logic [DATA_W-1:0] data;
  logic dout, tpe, ind, asleep, key_ok, pin_set, last;
  int miscompares = 0;
  int samples_checked = 0;
  int gap;
  int codes [PIN_LEN] = '{3, 5, 0, 7};

  remote_encoder #(.MS_CYCLES(MSC), .DIV_LO(8), .DIV_HI(4)) u_dut (
    .CLK(clk), .RST(rst), .KEY_IN(key_line), .SEND(send),
    .CREATE_PIN(create), .DATA_IN(data), .SEL_BAUD(1'b0),
    .SEL_TIMER(sel_timer), .DATA_OUT(dout), .TRANSMITTER_POWER_ENABLE(tpe),
    .STATUS_INDICATOR(ind), .ASLEEP(asleep), .KEY_VALID(key_ok),
    .PIN_SET(pin_set));
  key_link_model #(.DIV(8)) u_src (.clk(clk), .line(key_line));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %b want %b", $time, seen, exp);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task wait_for(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? tpe : asleep) !== v && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20000)
    begin
      miscompares++;
      $display("MISMATCH at %0t: wait ran out", $time);
    end
  endtask

  // an entry counts on release, so hold past the debounce both ways
  task press(input int idx);
    data[idx] <= 1'b1;
    repeat (DEB) @(posedge clk);
    ind_held = ind;
    data[idx] <= 1'b0;
    repeat (DEB) @(posedge clk);
  endtask

  task send_level(input logic v);
    send <= v;
    repeat (DEB) @(posedge clk);
  endtask

  task create_press();
    create <= 1'b1;
    repeat (DEB) @(posedge clk);
    create <= 1'b0;
    repeat (DEB) @(posedge clk);
  endtask

  // a short counter of 2 lets the key run out after two packets
  task get_key(input logic short_ctr);
    logic [7:0] b;
    for (int i = 0; i < FRAME_BYTES; i++)
    begin
      b = 8'h10 + 8'(i);
      if (short_ctr && i >= KEY_W / 8 && i < (KEY_W + CTR_W) / 8)
        b = (i == KEY_W / 8) ? 8'h02 : 8'h00;
      u_src.send_byte(b);
    end
    wait_for(0, 1'b1);
    check(asleep, 1'b0);
    wait_for(0, 1'b0);
    u_src.send_byte(8'ha5);
    repeat (20) @(posedge clk);
    check(ind, 1'b1);
    check(key_ok, 1'b1);
    check(pin_set, 1'b0);
    repeat (MSC * 1000 - 200) @(posedge clk);
    check(ind, 1'b1);
    repeat (400) @(posedge clk);
    check(ind, 1'b0);
    check(asleep, 1'b1);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    send = 1'b0;
    create = 1'b0;
    data = '0;
    ind_held = 1'b0;
    sel_timer = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check(asleep, 1'b1);
    check(tpe, 1'b0);
    send_level(1'b1);
    check(tpe, 1'b0);
    send_level(1'b0);
    get_key(1'b0);
    send_level(1'b1);
    check(tpe, 1'b1);
    check(asleep, 1'b0);
    gap = -1;
    last = dout;
    repeat (2000)
    begin
      @(posedge clk);
      if (gap >= 0)
        gap++;
      if (dout !== last)
      begin
        if (gap >= 0)
          check(gap % 8 == 0, 1'b1);
        gap = 0;
        last = dout;
      end
    end
    send_level(1'b0);
    wait_for(1, 1'b1);
    repeat (2) @(posedge clk);
    check(tpe, 1'b0);
    create_press();
    create_press();
    press(1);
    check(pin_set, 1'b0);
    create_press();
    check(ind, 1'b1);
    foreach (codes[i])
      press(codes[i]);
    check(pin_set, 1'b1);
    check(ind, 1'b0);
    send_level(1'b1);
    check(tpe, 1'b0);
    send_level(1'b0);
    foreach (codes[i])
    begin
      press(codes[i]);
      check(ind_held, 1'b1);
    end
    send_level(1'b1);
    check(tpe, 1'b1);
    send_level(1'b0);
    wait_for(1, 1'b1);
    get_key(1'b1);
    send_level(1'b1);
    check(tpe, 1'b1);
    check(key_ok, 1'b0);
    send_level(1'b0);
    wait_for(1, 1'b1);
    repeat (2) @(posedge clk);
    check(tpe, 1'b0);
    send_level(1'b1);
    check(tpe, 1'b0);
    summarize();
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
